/* verilog/mioc_defines.vh */
`ifndef MIOC_DEFINES_VH
`define MIOC_DEFINES_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define MIOC_OFF_SERIAL_IO 16'h0100
`define MIOC_OFF_INBAND 16'h0104
`define MIOC_OFF_INBAND_B1 16'h0105
`define MIOC_OFF_INBAND_B2 16'h0106
`define MIOC_OFF_INBAND_B3 16'h0107
// ----------------------------------------
// serial i/o control fields
// ----------------------------------------
`define MIOC_SIO_RESET 8'h42
`define MIOC_SIO_PREAMBLE_SUPP 2
`define MIOC_SIO_AUTO_EDGE 1
`define MIOC_SIO_MANUAL_EDGE 0
// ----------------------------------------
// in-band control fields
// ----------------------------------------
`define MIOC_IB_ENABLE 31
`define MIOC_IB_DA_MATCH 30
`define MIOC_IB_RESET 29
`define MIOC_IB_RESET_B3 5
`define MIOC_IB_PRIO_HI 23
`define MIOC_IB_PRIO_LO 22
`define MIOC_IB_PORT_HI 18
`define MIOC_IB_PORT_LO 16
`define MIOC_IB_TPID_HI 15
`define MIOC_IB_PRIO_RESET 2'h1
`define MIOC_IB_PORT_RESET 3'h0
`define MIOC_IB_TPID_RESET 16'h40FE
`define MIOC_IB_WMASK 32'hC0C7FFFF
`define MIOC_PORT_LAST 3'h2
// ----------------------------------------
// auto edge threshold
// ----------------------------------------
// a 25 MHz core cannot resolve sclk near 25 MHz, so a synchronised period at the
// two-cycle floor (count of 1 between rising edges) is taken as fast
`define MIOC_CORE_MHZ 25
`define MIOC_FAST_SCLK_MHZ 25
`define MIOC_FAST_COUNT_MAX 8'h01
`define MIOC_STATUS_MISMATCH 14
`endif

/* verilog/mioc_sclk_rate.v */
`include "mioc_defines.vh"
// ----------------------------------------
// measures serial clock period in core cycles
// ----------------------------------------
module mioc_sclk_rate (
   // clock and reset
   input wire i_clock,
   input wire i_rst,
   // synchronised serial clock
   input wire i_sclk_sync,
   // result
   output reg o_fast
);
   reg sclk_prev;
   reg [7:0] count;
   always @(posedge i_clock) begin
      if (i_rst) begin
         sclk_prev <= 1'h0;
         count <= 8'h00;
         o_fast <= 1'h0;
      end else begin
         sclk_prev <= i_sclk_sync;
         if (i_sclk_sync && !sclk_prev) begin
            // one rising edge per period; a count at the floor means sclk is at or above the threshold
            o_fast <= (count <= `MIOC_FAST_COUNT_MAX);
            count <= 8'h00;
         end else if (count != 8'hFF) begin
            count <= count + 8'h01;
         end
      end
   end
endmodule // mioc_sclk_rate

/* verilog/mioc_regs.v */
// Notes on behaviour
// - with preamble suppression clear the mdio slave needs a preamble, with it set it takes commands without one.
// - preamble suppression reaches only the mdio side and never the spi or i2c logic.
// - with auto edge on, spi read data launches on rising sclk at or above about 25 MHz, else on falling; the code picks rising at a two-cycle sclk period.
// - auto edge select resets to 1 and while set the manual edge bit is ignored.
// - with auto off, the manual edge bit (reset 0) picks falling for 0 and rising for 1.
// - in-band enable resets from the strap pin sampled at reset and is then written by software.
// - with in-band enable and address match both on, in-band frames for another destination mac are dropped.
// - writing 1 to the in-band reset bit restarts the in-band engine and the bit clears itself.
// - the two-bit response priority field, reset 01, selects the response transmit queue.
// - the port select field, reset 000, picks port 1, 2 or 3 with the other codes reserved.
// - the sixteen-bit field, reset 0x40FE, holds the ethertype that marks in-band frames.
// - an address mismatch with checking on sets the mismatch error flag, bit 14 of in-band status.
`include "mioc_defines.vh"
module mioc_regs (
   // clock and reset
   input wire i_clock,
   input wire i_rst,
   // register access from the management port logic
   input wire [15:0] i_addr,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   // strap and serial clock pins
   input wire i_inband_enable_strap_pin,
   input wire i_sclk,
   // in-band frame check
   input wire i_frame_valid,
   input wire [47:0] i_frame_dest_mac,
   input wire [47:0] i_switch_mac,
   input wire i_status_clear,
   // controls out
   output reg o_mdio_preamble_suppress,
   output reg o_spi_read_data_out_rising,
   output reg o_inband_enable,
   output reg o_inband_frame_drop,
   output reg o_inband_engine_reset,
   output reg [1:0] o_inband_resp_prio,
   output reg [2:0] o_inband_port,
   output reg o_inband_port_valid,
   output reg [15:0] o_inband_tpid,
   output reg o_inband_mismatch_err
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg strap_meta;
   reg strap_sync;
   reg sclk_meta;
   reg sclk_sync;
   reg strap_pending;
   always @(posedge i_clock) begin
      strap_meta <= i_inband_enable_strap_pin;
      strap_sync <= strap_meta;
      sclk_meta <= i_sclk;
      sclk_sync <= sclk_meta;
   end

   wire sclk_fast;
   mioc_sclk_rate u_rate (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_sclk_sync(sclk_sync),
      .o_fast(sclk_fast)
   );

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   reg [7:0] serial_io_control;
   reg [31:0] inband_mgmt_control;
   // reserved bits and the self-clearing bit are never stored, so they always read back as 0
   localparam [31:0] ib_write_mask = `MIOC_IB_WMASK;

   function is_wr;
      input [15:0] addr;
      input [15:0] off;
      input wr;
      begin
         is_wr = wr && (addr == off);
      end
   endfunction

   // a frame is turned away only while in-band access is on and the address check is asked for
   function da_reject;
      input valid;
      input enable;
      input match_en;
      input [47:0] dest;
      input [47:0] own;
      begin
         da_reject = valid && enable && match_en && (dest != own);
      end
   endfunction

   function port_code_ok;
      input [2:0] code;
      begin
         port_code_ok = (code <= `MIOC_PORT_LAST);
      end
   endfunction

   always @(posedge i_clock) begin
      if (i_rst) begin
         serial_io_control <= `MIOC_SIO_RESET;
         inband_mgmt_control <= {8'h00, `MIOC_IB_PRIO_RESET, 3'h0, `MIOC_IB_PORT_RESET,
            `MIOC_IB_TPID_RESET};
         strap_pending <= 1'h1;
      end else begin
         // strap is caught by a clocked load right after reset release
         // a byte-3 write in that same cycle comes later in this block and wins
         if (strap_pending) begin
            strap_pending <= 1'h0;
            inband_mgmt_control[`MIOC_IB_ENABLE] <= strap_sync;
         end
         if (is_wr(i_addr, `MIOC_OFF_SERIAL_IO, i_wr))
            serial_io_control <= i_wdata;
         // reset bit never stored: read as 0 at all times
         if (is_wr(i_addr, `MIOC_OFF_INBAND, i_wr))
            inband_mgmt_control[7:0] <= i_wdata;
         if (is_wr(i_addr, `MIOC_OFF_INBAND_B1, i_wr))
            inband_mgmt_control[15:8] <= i_wdata;
         if (is_wr(i_addr, `MIOC_OFF_INBAND_B2, i_wr))
            inband_mgmt_control[23:16] <= i_wdata & ib_write_mask[23:16];
         if (is_wr(i_addr, `MIOC_OFF_INBAND_B3, i_wr))
            inband_mgmt_control[31:24] <= i_wdata & ib_write_mask[31:24];
      end
   end

   // ----------------------------------------
   // derived controls
   // ----------------------------------------
   // sclk_fast is only a rate estimate; the manual bit is the way out for a host clock near the threshold
   wire edge_auto = serial_io_control[`MIOC_SIO_AUTO_EDGE];
   wire edge_manual = serial_io_control[`MIOC_SIO_MANUAL_EDGE];
   wire edge_rising = edge_auto ? sclk_fast : edge_manual;
   wire ib_enable = inband_mgmt_control[`MIOC_IB_ENABLE];
   wire ib_da_match = inband_mgmt_control[`MIOC_IB_DA_MATCH];
   wire frame_reject = da_reject(i_frame_valid, ib_enable, ib_da_match, i_frame_dest_mac, i_switch_mac);
   wire engine_restart = is_wr(i_addr, `MIOC_OFF_INBAND_B3, i_wr) && i_wdata[`MIOC_IB_RESET_B3];

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // read data is held until the next read so a slow host can pick it up late
   always @(posedge i_clock) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `MIOC_OFF_SERIAL_IO: o_rdata <= serial_io_control;
            `MIOC_OFF_INBAND: o_rdata <= inband_mgmt_control[7:0];
            `MIOC_OFF_INBAND_B1: o_rdata <= inband_mgmt_control[15:8];
            `MIOC_OFF_INBAND_B2: o_rdata <= inband_mgmt_control[23:16];
            `MIOC_OFF_INBAND_B3: o_rdata <= inband_mgmt_control[31:24];
            default: o_rdata <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // serial interface controls
   // ----------------------------------------
   always @(posedge i_clock) begin
      if (i_rst) begin
         o_mdio_preamble_suppress <= 1'h0;
         o_spi_read_data_out_rising <= 1'h0;
      end else begin
         // only the mdio slave sees this; spi and i2c paths take no input from it
         o_mdio_preamble_suppress <= serial_io_control[`MIOC_SIO_PREAMBLE_SUPP];
         o_spi_read_data_out_rising <= edge_rising;
      end
   end

   // ----------------------------------------
   // in-band configuration outputs
   // ----------------------------------------
   always @(posedge i_clock) begin
      if (i_rst) begin
         o_inband_enable <= 1'h0;
         o_inband_resp_prio <= `MIOC_IB_PRIO_RESET;
         o_inband_port <= `MIOC_IB_PORT_RESET;
         o_inband_port_valid <= 1'h1;
         o_inband_tpid <= `MIOC_IB_TPID_RESET;
      end else begin
         o_inband_enable <= ib_enable;
         o_inband_resp_prio <= inband_mgmt_control[`MIOC_IB_PRIO_HI:`MIOC_IB_PRIO_LO];
         o_inband_port <= inband_mgmt_control[`MIOC_IB_PORT_HI:`MIOC_IB_PORT_LO];
         // reserved codes pass through but are flagged, so the port mux can refuse them
         o_inband_port_valid <= port_code_ok(inband_mgmt_control[`MIOC_IB_PORT_HI:`MIOC_IB_PORT_LO]);
         o_inband_tpid <= inband_mgmt_control[`MIOC_IB_TPID_HI:0];
      end
   end

   // ----------------------------------------
   // engine restart pulse
   // ----------------------------------------
   // the bit is never stored, so the pulse cannot repeat and a read never sees it set
   always @(posedge i_clock) begin
      if (i_rst) begin
         o_inband_engine_reset <= 1'h0;
      end else begin
         o_inband_engine_reset <= engine_restart;
      end
   end

   // ----------------------------------------
   // destination check and mismatch flag
   // ----------------------------------------
   always @(posedge i_clock) begin
      if (i_rst) begin
         o_inband_frame_drop <= 1'h0;
         o_inband_mismatch_err <= 1'h0;
      end else begin
         o_inband_frame_drop <= frame_reject;
         // set wins over clear, so a mismatch in the clearing cycle is not lost
         if (frame_reject) begin
            o_inband_mismatch_err <= 1'h1;
         end else if (i_status_clear) begin
            o_inband_mismatch_err <= 1'h0;
         end
      end
   end
endmodule // mioc_regs

/* bench/mioc_regs_asserts.sv */
module mioc_regs_asserts (
   input wire i_clock, i_rst, i_wr, i_frame_valid,
   input wire [15:0] i_addr,
   input wire [7:0] i_wdata,
   input wire [47:0] i_frame_dest_mac, i_switch_mac,
   input wire o_mdio_preamble_suppress, o_inband_frame_drop, o_inband_engine_reset,
   input wire o_inband_port_valid, o_inband_mismatch_err,
   input wire [2:0] o_inband_port,
   input wire [15:0] o_inband_tpid
);
   timeunit 1ns;
   timeprecision 1ns;
   wire sc_wr = i_wr && i_addr == 16'h0107 && i_wdata[5];
   wire differ = i_frame_dest_mac != i_switch_mac;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);
   sc_set_a: assert property (sc_wr |=> o_inband_engine_reset)
      else $error("engine reset missing");
   sc_once_a: assert property (!sc_wr |=> !o_inband_engine_reset)
      else $error("engine reset stray");
   drop_why_a: assert property (o_inband_frame_drop |-> $past(i_frame_valid && differ))
      else $error("drop without mismatch");
   drop_keep_a: assert property (i_frame_valid && !differ |=> !o_inband_frame_drop)
      else $error("matching frame dropped");
   err_set_a: assert property (o_inband_frame_drop |-> o_inband_mismatch_err)
      else $error("mismatch flag missing");
   port_ok_a: assert property (o_inband_port_valid == (o_inband_port <= 3'h2))
      else $error("port valid wrong");
   tpid_wr_a: assert property (i_wr && i_addr == 16'h0104 |-> ##2 o_inband_tpid[7:0] == $past(i_wdata, 2))
      else $error("tpid low byte wrong");
   supp_wr_a: assert property (i_wr && i_addr == 16'h0100 |-> ##2 o_mdio_preamble_suppress == $past(i_wdata[2], 2))
      else $error("suppress bit wrong");
   rst_val_a: assert property ($fell(i_rst) |-> o_inband_tpid == 16'h40FE && o_inband_port == 3'h0)
      else $error("reset value wrong");
   c_sc: cover property (sc_wr ##1 o_inband_engine_reset);
   c_drop: cover property (o_inband_frame_drop);
   c_port: cover property (!o_inband_port_valid);
endmodule // mioc_regs_asserts
bind mioc_regs mioc_regs_asserts i_chk (.*);

/* bench/mioc_host_model.sv */
module mioc_host_model (
   input wire i_fast,
   input wire i_run,
   output logic o_sclk
);
   timeunit 1ns;
   timeprecision 1ns;
   // sclk stands low between frames
   initial begin
      o_sclk = 1'h0;
      forever begin
         #(i_fast ? 40 : 200);
         o_sclk = i_run ? ~o_sclk : 1'h0;
      end
   end
endmodule // mioc_host_model

/* bench/tb_top.sv */
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("unexpected %s %0h %0h", n, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clock, i_rst, wr, rd, strap, fv, sclr, fast, run, sclk, supp, rise, en, drop, ers, pv, merr;
   logic [15:0] addr, tpid;
   logic [7:0] wd, rdata;
   logic [47:0] dmac;
   logic [1:0] prio;
   logic [2:0] port;
   int err_total, num_checks;
   mioc_regs i_mioc_regs (.i_clock(i_clock), .i_rst(i_rst), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wd),
      .o_rdata(rdata), .i_inband_enable_strap_pin(strap), .i_sclk(sclk), .i_frame_valid(fv),
      .i_frame_dest_mac(dmac), .i_switch_mac(48'h0A0B0C0D0E0F), .i_status_clear(sclr),
      .o_mdio_preamble_suppress(supp), .o_spi_read_data_out_rising(rise), .o_inband_enable(en),
      .o_inband_frame_drop(drop), .o_inband_engine_reset(ers), .o_inband_resp_prio(prio),
      .o_inband_port(port), .o_inband_port_valid(pv), .o_inband_tpid(tpid), .o_inband_mismatch_err(merr));
   mioc_host_model i_mioc_host_model (.i_fast(fast), .i_run(run), .o_sclk(sclk));
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   task automatic wrb(input [15:0] a, input [7:0] d);
      cyc(1);
      addr = a;
      wd = d;
      wr = 1'h1;
      cyc(1);
      wr = 1'h0;
   endtask
   task automatic rdb(input [15:0] a, input [7:0] e);
      cyc(1);
      addr = a;
      rd = 1'h1;
      cyc(1);
      rd = 1'h0;
      `CHK("rdata", e, rdata)
   endtask
   task automatic frame(input [47:0] m, input c);
      cyc(1);
      dmac = m;
      fv = 1'h1;
      sclr = c;
      cyc(1);
      fv = 1'h0;
      sclr = 1'h0;
   endtask
   task automatic clr;
      cyc(1);
      sclr = 1'h1;
      cyc(1);
      sclr = 1'h0;
   endtask
   task automatic stop_test;
      if (err_total == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic t_reset;
      rdb(16'h0100, 8'h42);
      rdb(16'h0104, 8'hFE);
      rdb(16'h0105, 8'h40);
      rdb(16'h0106, 8'h40);
      rdb(16'h0107, 8'h80);
      `CHK("en", 1'h1, en)
      `CHK("pv", 1'h1, pv)
   endtask
   task automatic t_edge;
      wrb(16'h0100, 8'h01);
      cyc(2);
      `CHK("rise", 1'h1, rise)
      `CHK("supp", 1'h0, supp)
      wrb(16'h0100, 8'h04);
      cyc(2);
      `CHK("rise", 1'h0, rise)
      `CHK("supp", 1'h1, supp)
      wrb(16'h0100, 8'h03);
      run = 1'h1;
      cyc(40);
      `CHK("rise", 1'h0, rise)
      fast = 1'h1;
      cyc(40);
      `CHK("rise", 1'h1, rise)
      run = 1'h0;
   endtask
   task automatic t_inband;
      wrb(16'h0107, 8'hE0);
      `CHK("ers", 1'h1, ers)
      cyc(1);
      `CHK("ers", 1'h0, ers)
      rdb(16'h0107, 8'hC0);
      `CHK("ers", 1'h0, ers)
      frame(48'h0A0B0C0D0E01, 1'h0);
      `CHK("drop", 1'h1, drop)
      `CHK("merr", 1'h1, merr)
      frame(48'h0A0B0C0D0E0F, 1'h0);
      `CHK("drop", 1'h0, drop)
      clr;
      `CHK("merr", 1'h0, merr)
      frame(48'h0A0B0C0D0E01, 1'h1);
      `CHK("merr", 1'h1, merr)
      clr;
      `CHK("merr", 1'h0, merr)
      wrb(16'h0107, 8'h80);
      cyc(2);
      frame(48'h0A0B0C0D0E01, 1'h0);
      `CHK("drop", 1'h0, drop)
      `CHK("merr", 1'h0, merr)
      wrb(16'h0107, 8'h40);
      cyc(2);
      `CHK("en", 1'h0, en)
      frame(48'h0A0B0C0D0E01, 1'h0);
      `CHK("drop", 1'h0, drop)
      `CHK("merr", 1'h0, merr)
   endtask
   task automatic t_fields;
      wrb(16'h0106, 8'hC2);
      wrb(16'h0104, 8'h34);
      wrb(16'h0105, 8'h12);
      wrb(16'h0101, 8'hFF);
      cyc(2);
      `CHK("prio", 2'h3, prio)
      `CHK("port", 3'h2, port)
      `CHK("pv", 1'h1, pv)
      `CHK("tpid", 16'h1234, tpid)
      rdb(16'h0101, 8'h00);
      wrb(16'h0106, 8'hFF);
      rdb(16'h0106, 8'hC7);
      `CHK("port", 3'h7, port)
      `CHK("pv", 1'h0, pv)
   endtask
   task automatic t_strap;
      // second reset with the strap low: enable must come back clear
      cyc(1);
      strap = 1'h0;
      i_rst = 1'h1;
      cyc(12);
      i_rst = 1'h0;
      rdb(16'h0107, 8'h00);
      rdb(16'h0104, 8'hFE);
      cyc(1);
      `CHK("en", 1'h0, en)
      `CHK("port", 3'h0, port)
      `CHK("pv", 1'h1, pv)
   endtask
   initial begin
      i_clock = 1'h0;
      forever #20 i_clock = ~i_clock;
   end
   initial begin
      i_rst = 1'h1;
      strap = 1'h1;
      {wr, rd, fv, sclr, fast, run} = 6'h00;
      addr = 16'h0000;
      wd = 8'h00;
      dmac = 48'h000000000000;
      cyc(12);
      i_rst = 1'h0;
      t_reset;
      t_edge;
      t_inband;
      t_fields;
      t_strap;
      stop_test;
   end
   initial begin
      repeat (3000) @(posedge i_clock);
      err_total++;
      stop_test;
   end
endmodule // tb_top
